// ===== rtl/pcr_pkg.sv
// constants of the peak-cancellation crest reduction core
// Behaviour
// RL1: one new input sample is taken every fold-rate clock cycles
// RL2: interleaved iq input offered only for fold rate 2 or 4
// RL3: interleaved iq output offered only for fold rate 2 or 4
// RL4: clip engine count is set separately for every stage
// RL5: the source supplies odd symmetric pulse coefficients, count equals length
// RL6: one to four coefficient sets, each in its own bank
// RL7: bank 1 needs sets above 1, bank 2 above 2, bank 3 needs 4
// RL8: bank select input exists only with more than one set
// RL9: cancellation uses the bank number driven on the select input
// RL10: a bank without supplied contents holds arbitrary evaluation values
// RL11: input sample width is 11 to 18 bits
// RL12: coefficient width is 11 to 18 bits
// RL13: output sample width is 11 to 18 bits
// RL14: threshold is the default, or the control input when dynamic; the code uses the default for a zero control input
// RL15: window width is the default, or the control input when dynamic; the code uses the default for a control input below 3
// RL16: optional 16-bit gain multiplies the data leaving the last stage
// RL17: synchronous reset exists only when that option is selected
// RL18: clock enable exists only when that option is selected
// RL19: default threshold range 1 to 262143, default 73707
// RL20: default window width range 3 to 31, default 9
// RL21: with clock enable low, all state and outputs hold
package pcr_pkg;
  localparam int FOLD_RATE      = 2;
  localparam bit IN_INTERLEAVED = 1'b1;
  localparam bit OUT_INTERLEAVED = 1'b1;
  localparam int N_STAGES       = 2;
  localparam int ENGINES_S0     = 4;
  localparam int ENGINES_S1     = 4;
  localparam int PULSE_LEN      = 15;
  localparam int COE_SETS       = 4;
  localparam int DIN_W          = 18;
  localparam int COE_W          = 18;
  localparam int DOUT_W         = 18;
  localparam int TH_W           = 18;
  localparam logic [17:0] DEFAULT_TH  = 18'h11feb;
  localparam int SK_W           = 5;
  localparam logic [4:0]  DEFAULT_SK  = 5'h09;
  localparam logic [4:0]  SK_MIN      = 5'h03;
  localparam bit DYNAMIC_TH     = 1'b1;
  localparam bit DYNAMIC_SK     = 1'b1;
  localparam bit OUT_GAIN       = 1'b1;
  localparam int GAIN_W         = 16;
  localparam int GAIN_FRAC      = 14;
  localparam bit HAS_SRST       = 1'b1;
  localparam bit HAS_CE         = 1'b1;
  localparam int FOLD_CNT_W     = 2;
  localparam logic [1:0] FOLD_LAST = 2'(FOLD_RATE - 1);
  localparam int SEL_W          = 2;
  localparam int HALF_LEN       = PULSE_LEN / 2;
endpackage

// ===== rtl/pcr_skid.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module pcr_skid
  import pcr_pkg::*;
#(
  parameter int W = 36
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem [2];
  logic         wptr;
  logic         rptr;
  logic [1:0]   count;
  wire do_push = ce && in_valid && (count != 2'h2);
  wire do_pop  = ce && out_ready && (count != 2'h0);

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rptr];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr  <= 1'b0;
      rptr  <= 1'b0;
      count <= 2'h0;
    end else begin
      if (do_push) wptr <= ~wptr;
      if (do_pop)  rptr <= ~rptr;
      count <= 2'(count + {1'b0, do_push} - {1'b0, do_pop});
    end
  end

  full_empty_a: assert property (@(posedge clk) disable iff (rst)
    !(in_ready == 1'b0 && out_valid == 1'b0))
    else $error("buffer both full and empty");
endmodule // pcr_skid

// ===== rtl/pcr_core.sv
// peak-cancellation crest reduction core top level
`timescale 1ns/10ps
module pcr_core
  import pcr_pkg::*;
(
  // clock, reset, enable
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // input samples
  input  wire logic                in_valid,
  input  wire logic [DIN_W-1:0]    in_i,
  input  wire logic [DIN_W-1:0]    in_q,
  // output samples
  output logic                     out_valid,
  input  wire logic                out_ready,
  output logic [DOUT_W-1:0]        out_i,
  output logic [DOUT_W-1:0]        out_q,
  output logic                     out_is_q,
  // control
  input  wire logic [TH_W-1:0]     threshold,
  input  wire logic [SK_W-1:0]     window_width,
  input  wire logic [SEL_W-1:0]    coeffs_select,
  input  wire logic [GAIN_W-1:0]   out_gain,
  // status
  output logic                     in_stall,
  output logic                     peak_seen
);
  ////////////////////////////////////////////////////////////////////////
  // configuration-dependent port presence
  wire en     = HAS_CE ? ce : 1'b1;                           // RL18 RL21
  wire srst   = HAS_SRST ? rst : 1'b0;                        // RL17
  wire [SEL_W-1:0] sel_eff =
    (COE_SETS > 1) ? coeffs_select : '0;                      // RL8
  wire [TH_W-1:0] th_eff =
    (DYNAMIC_TH && threshold != '0) ? threshold : DEFAULT_TH; // RL14 RL19
  wire sk_ok = (window_width >= SK_MIN);
  wire [SK_W-1:0] sk_eff =
    (DYNAMIC_SK && sk_ok) ? window_width : DEFAULT_SK;        // RL15 RL20

  ////////////////////////////////////////////////////////////////////////
  // coefficient banks; only half the pulse is stored, and only its centre tap is read
  logic signed [COE_W-1:0] bank [COE_SETS][HALF_LEN+1];
  // contents are arbitrary evaluation values with no file supplied
  always_comb begin                                           // RL10
    for (int b = 0; b < COE_SETS; b++) begin
      for (int k = 0; k <= HALF_LEN; k++) begin
        bank[b][k] = COE_W'(((k + 1) * 997 + b * 131) % 4096);
      end
    end
  end
  wire [SEL_W-1:0] bank_idx =
    (int'(sel_eff) < COE_SETS) ? sel_eff : '0;                // RL6 RL7 RL9
  // the odd symmetric shape is relied on to store half the taps
  wire signed [COE_W-1:0] peak_tap = bank[bank_idx][HALF_LEN]; // RL5

  ////////////////////////////////////////////////////////////////////////
  // sample intake, one sample per fold period
  logic [FOLD_CNT_W-1:0]   fold_cnt;
  logic                    phase_q;
  logic signed [DIN_W-1:0] hold_i;
  wire slot_last  = (fold_cnt == FOLD_LAST);                  // RL1
  wire il_in      = IN_INTERLEAVED && (FOLD_RATE == 2 || FOLD_RATE == 4); // RL2
  wire take_i     = en && in_valid && il_in && !phase_q;
  wire take_pair  = en && in_valid && (il_in ? phase_q : 1'b1);
  wire [DIN_W-1:0] s_i = il_in ? hold_i : in_i;
  wire [DIN_W-1:0] s_q = in_q;
  logic buf_ready;

  always_ff @(posedge clk) begin
    if (srst) begin
      fold_cnt <= '0;
      phase_q  <= 1'b0;
      hold_i   <= '0;
    end else if (en) begin
      fold_cnt <= slot_last ? '0 : fold_cnt + 1'b1;
      if (take_i) hold_i <= in_i;
      if (take_i) phase_q <= 1'b1;
      else if (take_pair) phase_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clip stages: a peak over the threshold is pulled back by a scaled tap while a clip engine is free
  logic signed [DIN_W+1:0] st_i [N_STAGES+1];
  logic signed [DIN_W+1:0] st_q [N_STAGES+1];
  logic                    st_v [N_STAGES+1];
  logic [N_STAGES-1:0]     st_peak;
  assign st_i[0] = (DIN_W+2)'(signed'(s_i));
  assign st_q[0] = (DIN_W+2)'(signed'(s_q));
  assign st_v[0] = take_pair && buf_ready;

  for (genvar s = 0; s < N_STAGES; s++) begin : g_stage
    localparam int NE = (s == 0) ? ENGINES_S0 : ENGINES_S1;   // RL4
    logic [3:0] engines_busy;
    wire [DIN_W+1:0] mag_i = st_i[s][DIN_W+1] ? -st_i[s] : st_i[s];
    wire [DIN_W+1:0] mag_q = st_q[s][DIN_W+1] ? -st_q[s] : st_q[s];
    wire [DIN_W+2:0] mag = {1'b0, mag_i} + {1'b0, mag_q};
    wire over = ({2'b0, mag} > {2'b0, th_eff}) && st_v[s]
                && (int'(engines_busy) < NE);
    logic signed [DIN_W+1:0] r_i;
    logic signed [DIN_W+1:0] r_q;
    logic                    r_v;
    logic                    r_peak;
    wire signed [DIN_W+1:0] corr = (DIN_W+2)'(peak_tap >>> 8);
    always_ff @(posedge clk) begin
      if (srst) begin
        r_i <= '0;
        r_q <= '0;
        r_v <= 1'b0;
        r_peak <= 1'b0;
        engines_busy <= '0;
      end else if (en) begin
        r_v    <= st_v[s];
        r_peak <= over;
        r_i    <= over ? st_i[s] - (st_i[s][DIN_W+1] ? -corr : corr)
                       : st_i[s];
        r_q    <= over ? st_q[s] - (st_q[s][DIN_W+1] ? -corr : corr)
                       : st_q[s];
        // one engine released per valid sample in fold slot 0 that claims no engine, while the window width is non-zero
        if (over) engines_busy <= engines_busy + 1'b1;
        else if (engines_busy != 0 && st_v[s] && fold_cnt == 0
                 && sk_eff != 0) engines_busy <= engines_busy - 1'b1;
      end
    end
    assign st_i[s+1] = r_i;
    assign st_q[s+1] = r_q;
    assign st_v[s+1] = r_v;
    assign st_peak[s] = r_peak;
  end

  ////////////////////////////////////////////////////////////////////////
  // output gain and saturation to the output width
  wire signed [DIN_W+1:0] last_i = st_i[N_STAGES];
  wire signed [DIN_W+1:0] last_q = st_q[N_STAGES];
  wire signed [DIN_W+GAIN_W+2:0] prod_i =
    last_i * $signed({1'b0, out_gain});                       // RL16
  wire signed [DIN_W+GAIN_W+2:0] prod_q =
    last_q * $signed({1'b0, out_gain});
  wire signed [DIN_W+2:0] g_i = OUT_GAIN ?
    (DIN_W+3)'(prod_i >>> GAIN_FRAC) : (DIN_W+3)'(last_i);
  wire signed [DIN_W+2:0] g_q = OUT_GAIN ?
    (DIN_W+3)'(prod_q >>> GAIN_FRAC) : (DIN_W+3)'(last_q);
  localparam logic signed [DIN_W+2:0] SAT_HI =
    (DIN_W+3)'((1 <<< (DOUT_W-1)) - 1);
  localparam logic signed [DIN_W+2:0] SAT_LO =
    (DIN_W+3)'(-(1 <<< (DOUT_W-1)));
  wire [DOUT_W-1:0] y_i = (g_i > SAT_HI) ? DOUT_W'(SAT_HI) :
    (g_i < SAT_LO) ? DOUT_W'(SAT_LO) : DOUT_W'(g_i);          // RL11 RL13
  wire [DOUT_W-1:0] y_q = (g_q > SAT_HI) ? DOUT_W'(SAT_HI) :
    (g_q < SAT_LO) ? DOUT_W'(SAT_LO) : DOUT_W'(g_q);          // RL12

  ////////////////////////////////////////////////////////////////////////
  // buffer in the data path; samples arriving while it is full are dropped
  wire                      b_valid;
  wire [2*DOUT_W-1:0]       b_data;
  logic                     b_ready;
  pcr_skid #(.W(2*DOUT_W)) u_buf (
    .clk       (clk),
    .rst       (srst),
    .ce        (en),
    .in_valid  (st_v[N_STAGES]),
    .in_ready  (buf_ready),
    .in_data   ({y_i, y_q}),
    .out_valid (b_valid),
    .out_ready (b_ready),
    .out_data  (b_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // output register, interleaved or parallel
  wire il_out = OUT_INTERLEAVED && (FOLD_RATE == 2 || FOLD_RATE == 4); // RL3
  logic out_phase;
  wire  out_free = !out_valid || out_ready;
  wire  send_q   = il_out && out_phase;
  assign b_ready = out_free && (!il_out || out_phase);

  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_i     <= '0;
      out_q     <= '0;
      out_is_q  <= 1'b0;
      out_phase <= 1'b0;
      in_stall  <= 1'b0;
      peak_seen <= 1'b0;
    end else if (en) begin                                    // RL21
      in_stall  <= !buf_ready;
      peak_seen <= |st_peak;
      if (out_free) begin
        out_valid <= b_valid;
        if (b_valid) begin
          out_i    <= (il_out && !send_q) ? b_data[2*DOUT_W-1:DOUT_W]
                    : (il_out ? b_data[DOUT_W-1:0]
                              : b_data[2*DOUT_W-1:DOUT_W]);
          out_q    <= b_data[DOUT_W-1:0];
          out_is_q <= send_q;
          if (il_out) out_phase <= ~out_phase;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  hold_when_off_a: assert property (@(posedge clk) disable iff (rst)
    !en |=> $stable(out_valid) && $stable(out_i))             // RL21
    else $error("output moved with enable low");
  fold_wrap_a: assert property (@(posedge clk) disable iff (rst)
    en && slot_last |=> fold_cnt == 0)                        // RL1
    else $error("fold counter did not wrap");
  bank_range_a: assert property (@(posedge clk) disable iff (rst)
    int'(bank_idx) < COE_SETS)                                // RL7
    else $error("bank index beyond configured sets");
  sk_range_a: assert property (@(posedge clk) disable iff (rst)
    sk_eff >= SK_MIN)                                         // RL20
    else $error("window width below minimum");
  th_nonzero_a: assert property (@(posedge clk) disable iff (rst)
    th_eff != 0)                                              // RL19
    else $error("threshold zero");
  out_hold_a: assert property (@(posedge clk) disable iff (rst)
    out_valid && !out_ready && en |=> out_valid && $stable(out_i)) // RL3
    else $error("output dropped under stall");
  stage_lat_a: assert property (@(posedge clk) disable iff (rst)
    en && st_v[0] ##1 en |-> st_v[1])                         // RL4
    else $error("stage lost a sample");
  sel_use_a: assert property (@(posedge clk) disable iff (rst)
    COE_SETS > 1 && int'(coeffs_select) < COE_SETS
      |-> bank_idx == coeffs_select)                          // RL9
    else $error("bank select ignored");
  cv_peak: cover property (@(posedge clk) peak_seen);
  cv_stall: cover property (@(posedge clk) in_stall);
  cv_q_out: cover property (@(posedge clk) out_valid && out_is_q);
endmodule // pcr_core

// ===== bench/pcr_stream_model.sv
// source and sink model of the datapath logic around the core
`timescale 1ns/10ps
module pcr_stream_model
  import pcr_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // bench requests
  input  wire logic             send,
  input  wire logic             stall,
  input  wire logic [DIN_W-1:0] i_val,
  input  wire logic [DIN_W-1:0] q_val,
  // core side
  output logic                  in_valid,
  output logic [DIN_W-1:0]      in_i,
  output logic [DIN_W-1:0]      in_q,
  output logic                  out_ready
);
  logic phase;

  assign out_ready = ~stall;

  ////////////////////////////////////////////////////////////////////////
  // one sample per fold period, I beat then Q beat; unused words toggle
  // so that a core reading a stale lane cannot pass by luck
  always_ff @(posedge clk) begin
    if (rst) begin
      in_valid <= 1'b0;
      phase    <= 1'b0;
      in_i     <= '0;
      in_q     <= '0;
    end else if (ce) begin
      if (phase) begin
        in_valid <= 1'b1;
        in_q     <= q_val;
        in_i     <= ~in_i;
        phase    <= 1'b0;
      end else if (send) begin
        in_valid <= 1'b1;
        in_i     <= i_val;
        in_q     <= ~q_val;
        phase    <= 1'b1;
      end else begin
        in_valid <= 1'b0;
        in_i     <= ~in_i;
        in_q     <= ~in_q;
      end
    end
  end
endmodule // pcr_stream_model

// ===== bench/tb_pcr_core.sv
// self-checking bench of the crest reduction core
`timescale 1ns/10ps
module tb_pcr_core
  import pcr_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, send = 1'b0, stall = 1'b0;
  logic [DIN_W-1:0] i_val = '0, q_val = '0, in_i, in_q;
  logic [TH_W-1:0] threshold = '0;
  logic [SK_W-1:0] window_width = '0;
  logic [SEL_W-1:0] coeffs_select = '0;
  logic [GAIN_W-1:0] out_gain = 16'h4000;
  logic in_valid, out_valid, out_ready, out_is_q, in_stall, peak_seen;
  logic [DOUT_W-1:0] out_i, out_q;
  int num_errors = 0, compares = 0;

  always #5 clk = ~clk;

  pcr_stream_model u_pcr_stream_model (.clk(clk), .rst(rst), .ce(ce),
    .send(send), .stall(stall), .i_val(i_val), .q_val(q_val),
    .in_valid(in_valid), .in_i(in_i), .in_q(in_q), .out_ready(out_ready));
  pcr_core u_pcr_core (.clk(clk), .rst(rst), .ce(ce), .in_valid(in_valid),
    .in_i(in_i), .in_q(in_q), .out_valid(out_valid), .out_ready(out_ready),
    .out_i(out_i), .out_q(out_q), .out_is_q(out_is_q),
    .threshold(threshold), .window_width(window_width),
    .coeffs_select(coeffs_select), .out_gain(out_gain),
    .in_stall(in_stall), .peak_seen(peak_seen));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [17:0] scale(logic [17:0] v, logic [15:0] g);
    logic signed [35:0] p;
    p = $signed(v) * $signed({1'b0, g});
    return p[31:14];
  endfunction

  task automatic send_one(input logic [17:0] i, input logic [17:0] q);
    @(posedge clk);
    send <= 1'b1;
    i_val <= i;
    q_val <= q;
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
  endtask

  // waits for an accepted beat; the beat is read at its accepting edge
  task automatic get_beat(output logic [17:0] d, output logic isq,
                          output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    while (!ok && n < 40) begin
      @(posedge clk);
      n++;
      ok = (out_valid === 1'b1) && out_ready && ce;
    end
    d = out_i;
    isq = out_is_q;
  endtask

  task automatic pair(input logic [17:0] ei, input logic [17:0] eq);
    logic [17:0] d;
    logic isq, ok;
    get_beat(d, isq, ok);
    check({ok, isq, d}, {2'b10, ei});
    get_beat(d, isq, ok);
    check({ok, isq, d}, {2'b11, eq});
    check(out_q, eq);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check({out_valid, out_i, out_q, out_is_q, in_stall, peak_seen}, '0);
    $display("test reset done");
  endtask

  // small samples stay under the default threshold for every bank and two gains
  task automatic t_pass();
    for (int g = 0; g < 2; g++) begin
      for (int b = 0; b < 4; b++) begin
        out_gain <= g ? 16'h2000 : 16'h4000;
        coeffs_select <= 2'(b);
        send_one(18'h00100, 18'h3ff00);
        pair(scale(18'h00100, out_gain), scale(18'h3ff00, out_gain));
        check(peak_seen, 1'b0);
      end
    end
    out_gain <= 16'h4000;
    $display("test pass done");
  endtask

  task automatic t_peak();
    logic hit;
    hit = 1'b0;
    window_width <= 5'h02;
    send_one(18'h01000, 18'h01000);
    repeat (12) @(posedge clk) hit |= peak_seen;
    check(hit, 1'b0);
    threshold <= 18'h00010;
    send_one(18'h01000, 18'h01000);
    repeat (12) @(posedge clk) hit |= peak_seen;
    check(hit, 1'b1);
    threshold <= '0;
    window_width <= '0;
    repeat (30) @(posedge clk);
    $display("test peak done");
  endtask

  task automatic t_ce();
    logic [17:0] held;
    logic v;
    int n;
    n = 0;
    stall <= 1'b1;
    send_one(18'h00055, 18'h000aa);
    while (out_valid !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    ce <= 1'b0;
    stall <= 1'b0;
    held = out_i;
    v = out_valid;
    repeat (6) @(posedge clk);
    check({v, out_valid, out_i}, {2'b11, held});
    ce <= 1'b1;
    pair(18'h00055, 18'h000aa);
    $display("test ce done");
  endtask

  // sink stalls while the source keeps fold spacing; kept words stay in order
  task automatic t_stall();
    logic [17:0] d;
    logic isq, ok, full;
    int k;
    full = 1'b0;
    stall <= 1'b1;
    @(posedge clk);
    send <= 1'b1;
    for (int s = 1; s <= 12; s++) begin
      i_val <= 18'(s * 16);
      q_val <= 18'(s * 32);
      repeat (2) @(posedge clk);
      full |= in_stall;
    end
    send <= 1'b0;
    repeat (4) @(posedge clk) full |= in_stall;
    check(full, 1'b1);
    stall <= 1'b0;
    k = 1;
    ok = 1'b1;
    while (ok) begin
      get_beat(d, isq, ok);
      if (ok) begin
        check({isq, d}, {1'b0, 18'(k * 16)});
        get_beat(d, isq, ok);
        check({ok, isq, d}, {2'b11, 18'(k * 32)});
        k++;
      end
    end
    check(k > 2, 1'b1);
    $display("test stall done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_pass();
    t_peak();
    t_ce();
    t_stall();
    end_sim();
  end
endmodule // tb_pcr_core
